// File: include/ones_count_bit_test_map.svh
`ifndef ONES_COUNT_BIT_TEST_MAP_SVH
`define ONES_COUNT_BIT_TEST_MAP_SVH
`define NARROW_BITS      16
`define WIDE_BITS        32
`define INDEX_BITS       5
`define NARROW_INDEX_MAX 5'h0f
`define COUNT_ZERO       16'h0000
`define WORD_ZERO        32'h0000_0000
`define DIGIT_BITS       4
`define DIGIT_COUNT      8
`define COUNT_BITS       16
`define NIBBLE_SUM_BITS  3
`define NIBBLE_SUM_ZERO  3'h0
`define WORD_ONE         32'h0000_0001
`define DECIMAL_RADIX    32'h0000_000a
`endif

// File: include/ones_count_bit_test_pkg.sv
`include "ones_count_bit_test_map.svh"
package ones_count_bit_test_pkg;
    typedef enum logic [2:0] {
        op_none,
        op_ones_count,
        op_ones_count_wide,
        op_bit_probe,
        op_bit_probe_wide
    } op_kind_t;

    typedef struct packed {
        op_kind_t                   kind;
        logic                       pulse_form;
        logic                       source_is_decimal;
        logic [`WIDE_BITS-1:0]      source;
        logic [`INDEX_BITS-1:0]     bit_index;
    } op_request_t;

    typedef struct packed {
        logic [`WIDE_BITS-1:0]      dest_word;
        logic                       dest_bit;
        logic                       zero_flag;
        logic                       execution_state_out;
        logic                       done;
    } op_result_t;

    typedef struct packed {
        logic                       enable_last;
        op_result_t                 result;
    } unit_state_t;
endpackage

// File: core/ones_count_bit_test.sv
`timescale 1ns/100ps
// the request word and the condition are looked at on every edge.
// results are registered, so an answer stands right after the
// edge on which its request fired, and then holds until the next
// firing edge or a reset.
//
// all arithmetic is one clock of flat logic; the bcd conversion is
// the long path and sets the clock limit of this block. a pipelined
// version would trade a clock of latency for that path.
module ones_count_bit_test
    import ones_count_bit_test_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        exec_condition,
    input  wire op_request_t request,
    output op_result_t       result
);
    unit_state_t                                        state_reg;
    unit_state_t                                        state_next;

    // request decode
    logic                                               kind_is_count;
    logic                                               kind_is_probe;
    logic                                               kind_is_wide;
    logic                                               fire;

    // ones count path
    wire logic [`WIDE_BITS-1:0]                         counted_bits;
    wire logic [`DIGIT_COUNT-1:0][`NIBBLE_SUM_BITS-1:0] nibble_count;
    logic      [`COUNT_BITS-1:0]                        ones_total;
    logic                                               source_all_zero;

    // bit probe path
    wire logic [`DIGIT_COUNT-1:0][`WIDE_BITS-1:0]       digit_term;
    logic      [`WIDE_BITS-1:0]                         decimal_value;
    logic      [`WIDE_BITS-1:0]                         probe_source;
    logic      [`INDEX_BITS-1:0]                        probe_index;
    logic                                               probe_value;

    // ten to the given power: the weight of one bcd digit position
    function automatic logic [`WIDE_BITS-1:0] decimal_weight(
        input int position
    );
        logic [`WIDE_BITS-1:0] weight;
        weight = `WORD_ONE;
        for (int p = 0; p < position; p++) begin
            weight = weight * `DECIMAL_RADIX;
        end
        return weight;
    endfunction

    // ones in one group of four source bits
    function automatic logic [`NIBBLE_SUM_BITS-1:0] nibble_ones(
        input logic [`DIGIT_BITS-1:0] group
    );
        logic [`NIBBLE_SUM_BITS-1:0] sum;
        sum = `NIBBLE_SUM_ZERO;
        for (int i = 0; i < `DIGIT_BITS; i++) begin
            sum = sum + `NIBBLE_SUM_BITS'(group[i]);
        end
        return sum;
    endfunction

    // group counts added into the 16-bit count width, the low half of the destination; the widest
    // possible total is the wide operand width, so nothing overflows
    function automatic logic [`COUNT_BITS-1:0] add_counts(
        input logic [`DIGIT_COUNT-1:0][`NIBBLE_SUM_BITS-1:0] counts
    );
        logic [`COUNT_BITS-1:0] total;
        total = `COUNT_ZERO;
        for (int g = 0; g < `DIGIT_COUNT; g++) begin
            total = total + `COUNT_BITS'(counts[g]);
        end
        return total;
    endfunction

    // weighted digits summed into one binary word
    function automatic logic [`WIDE_BITS-1:0] add_terms(
        input logic [`DIGIT_COUNT-1:0][`WIDE_BITS-1:0] terms
    );
        logic [`WIDE_BITS-1:0] acc;
        acc = `WORD_ZERO;
        for (int g = 0; g < `DIGIT_COUNT; g++) begin
            acc = acc + terms[g];
        end
        return acc;
    endfunction

    // which family the request belongs to, and at which width
    assign kind_is_count = (request.kind == op_ones_count)
                        || (request.kind == op_ones_count_wide);
    assign kind_is_probe = (request.kind == op_bit_probe)
                        || (request.kind == op_bit_probe_wide);
    assign kind_is_wide  = (request.kind == op_ones_count_wide)
                        || (request.kind == op_bit_probe_wide);

    // a pulse form needs the condition low on the edge before; the
    // held copy of the condition makes a long high level fire once
    assign fire = exec_condition
               && (!request.pulse_form || !state_reg.enable_last);

    // narrow counts see only the low half; masking the high half per bit
    // lets one adder and one zero test serve both widths
    for (genvar b = 0; b < `WIDE_BITS; b++) begin : g_mask
        if (b < `NARROW_BITS) begin : g_low
            assign counted_bits[b] = request.source[b];
        end else begin : g_high
            assign counted_bits[b] = request.source[b] & kind_is_wide;
        end
    end

    // one group of four bits is both a count slice and a bcd digit
    for (genvar g = 0; g < `DIGIT_COUNT; g++) begin : g_group
        assign nibble_count[g] = nibble_ones(
            counted_bits[g*`DIGIT_BITS +: `DIGIT_BITS]);
        // a digit above nine is taken at its raw value; such a source
        // is the program's mistake and gives a defined, useless bit
        assign digit_term[g] = `WIDE_BITS'(
            request.source[g*`DIGIT_BITS +: `DIGIT_BITS])
            * decimal_weight(g);
    end

    assign ones_total      = add_counts(nibble_count);
    assign source_all_zero = (counted_bits == `WORD_ZERO);

    // decimal sources are converted before the bit is picked
    assign decimal_value = add_terms(digit_term);
    assign probe_source  = request.source_is_decimal
                         ? decimal_value
                         : request.source;

    // an index beyond the narrow width is the program's fault; it is
    // masked so that a narrow probe never reads the high half
    assign probe_index = kind_is_wide
                       ? request.bit_index
                       : (request.bit_index & `NARROW_INDEX_MAX);
    assign probe_value = probe_source[probe_index];

    always_comb begin
        state_next = state_reg;
        state_next.enable_last = exec_condition;
        state_next.result.execution_state_out = exec_condition;
        state_next.result.done = 1'b0;
        if (fire && kind_is_count) begin
            // high destination word always written as zero
            state_next.result.dest_word =
                {`COUNT_ZERO, ones_total};
            state_next.result.zero_flag = source_all_zero;
            state_next.result.done = 1'b1;
        end else if (fire && kind_is_probe) begin
            state_next.result.dest_bit = probe_value;
            state_next.result.done = 1'b1;
        end
        // refused edges keep the held copy of every destination
        // op_none fires nothing, so it never raises done either
    end

    // the only state: one registered copy of the whole unit
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs come straight from the register
    assign result = state_reg.result;
endmodule

// File: bench/count_probe_checker.sv
`timescale 1ns/100ps
module count_probe_checker import ones_count_bit_test_pkg::*; (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        exec_condition,
    input wire op_request_t request,
    input wire op_result_t  result);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire op_kind_t    k = request.kind;
    wire logic [31:0] s = request.source;
    sequence s_go; exec_condition && !(request.pulse_form
        && $past(exec_condition)); endsequence
    property p_nar; s_go ##0 k == op_ones_count |=> result.zero_flag
        == !$past(|s[15:0]) && result.dest_word == $countones($past(s[15:0]));
    endproperty
    property p_wid; s_go ##0 k == op_ones_count_wide |=>
        result.dest_word == $countones($past(s)); endproperty
    property p_hld; !exec_condition |=> $stable(result.dest_word); endproperty
    property p_bit; s_go ##0 k == op_bit_probe_wide ##0
        !request.source_is_decimal
        |=> result.dest_bit == $past(s[request.bit_index]); endproperty
    property p_one; exec_condition && $past(exec_condition)
        && request.pulse_form |=> !result.done; endproperty
    property p_zwd; s_go ##0 k == op_ones_count_wide |=>
        result.zero_flag == ($past(s) == 32'h0000_0000); endproperty
    property p_prb; s_go ##0 k == op_bit_probe ##0
        !request.source_is_decimal
        |=> result.dest_bit == $past(s[request.bit_index[3:0]]);
    endproperty
    property p_don; s_go ##0 k != op_none |=> result.done; endproperty
    a_nar: assert property (p_nar) else $error("narrow count");
    a_wid: assert property (p_wid) else $error("wide count");
    a_hld: assert property (p_hld) else $error("dest moved");
    a_bit: assert property (p_bit) else $error("probe bit");
    a_one: assert property (p_one) else $error("pulse again");
    a_zwd: assert property (p_zwd) else $error("wide zero");
    a_prb: assert property (p_prb) else $error("narrow probe");
    a_don: assert property (p_don) else $error("no done");
endmodule
bind ones_count_bit_test count_probe_checker checker_i (.clk(clk),
    .reset(reset), .exec_condition(exec_condition), .request(request),
    .result(result));

// File: bench/testbench.sv
`timescale 1ns/100ps
module testbench import ones_count_bit_test_pkg::*;;
    logic        clk = 0, reset = 1, exec_condition = 0;
    op_request_t request = '0;
    op_result_t  result;
    int          errors = 0, n_checks = 0;
    ones_count_bit_test dut (.clk(clk), .reset(reset),
        .exec_condition(exec_condition), .request(request), .result(result));
    initial forever #2.5 clk = ~clk;
    task automatic chk(logic [31:0] got, exp);
        n_checks++;
        errors += (got !== exp);
        if (got !== exp) $display("unexpected %0t %h %h", $time, got, exp);
    endtask
    // pulse ops leave the condition high so a repeat firing would show
    task automatic op(op_kind_t k, logic p, d, logic [31:0] s,
                      logic [4:0] i, logic [31:0] x);
        @(posedge clk) exec_condition <= 1'b1;
        request <= '{k, p, d, s, i};
        @(posedge clk) exec_condition <= p;
        #1 chk(k > op_ones_count_wide ? result.dest_bit : result.dest_word, x);
    endtask
    task automatic t_count;
        op(op_ones_count, 1'b0, 1'b0, 32'hffff_0000, 5'h00, 32'h0);
        chk(result.zero_flag, 32'h1);
        op(op_ones_count_wide, 1'b0, 1'b0, 32'hffff_fffb, 5'h00, 32'h1f);
        chk(result.zero_flag, 32'h0);
        chk(result.execution_state_out, 32'h1);
        op(op_ones_count_wide, 1'b0, 1'b0, 32'h0000_0000, 5'h00, 32'h0);
        chk(result.zero_flag, 32'h1);
        op(op_ones_count, 1'b0, 1'b0, 32'h0000_fffd, 5'h00, 32'h0f);
        chk(result.zero_flag, 32'h0);
        repeat (2) @(posedge clk) request.source <= 32'h0000_0000;
        #1 chk(result.dest_word, 32'h0000_000f);
    endtask
    task automatic t_probe;
        op(op_bit_probe, 1'b0, 1'b0, 32'h0000_8000, 5'h0f, 32'h1);
        op(op_bit_probe_wide, 1'b0, 1'b0, 32'h7fff_ffff, 5'h1f, 32'h0);
        op(op_bit_probe_wide, 1'b0, 1'b1, 32'h0000_0512, 5'h09, 32'h1);
    endtask
    task automatic t_pulse;
        op(op_ones_count, 1'b1, 1'b0, 32'h0000_0007, 5'h00, 32'h3);
        chk(result.done, 32'h1);
        @(posedge clk) #1 chk(result.done, 32'h0);
        @(posedge clk) exec_condition <= 1'b0;
    endtask
    task automatic print_verdict;
        $display("errors %0d checks %0d", errors, n_checks);
        if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        t_count;
        t_probe;
        t_pulse;
        print_verdict;
    end
endmodule
